// ---- bench/smr_frame_sink.sv ----
// Link receiver model that collects sideband monitor frames
module smr_frame_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire smr_pkg::smr_frame_t frame_out,
  output int frames,
  output smr_pkg::smr_frame_t last
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge mclk)
  begin
    if (rst)
      frames <= 0;
    else if (frame_out.valid)
    begin
      frames <= frames + 1;
      last <= frame_out;
    end
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the monitor readback and frame source
`include "smr_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0;
  logic rst = 1;
  logic hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [19:0] sample_mag = '0;
  logic sample_valid = 0;
  smr_pkg::smr_frame_t frame_out;
  smr_pkg::smr_frame_t last;
  int frames;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [7:0] cnt;
  // Full-width samples so the high result nibble can be exercised
  smr_framer #(.SAMPLE_W(20)) dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_mag(sample_mag), .sample_valid(sample_valid), .frame_out(frame_out));
  smr_frame_sink sink (.mclk(mclk), .rst(rst), .frame_out(frame_out), .frames(frames), .last(last));
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  // Waits for hready high at a rising edge, seen at the falling edge before it
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge mclk);
      r = hreadyout;
      d = hrdata;
      @(posedge mclk);
      if (r === 1'b1)
        return;
    end
    err_count++;
    stop_test();
  endtask
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= w;
    wait_rdy(d);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= wd;
    wait_rdy(d);
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    bus(0, idx, '0, rd);
    check(rd, exp);
  endtask
  task automatic wait_frame();
    int n0;
    n0 = frames;
    for (int i = 0; i < 300; i++)
    begin
      @(posedge mclk);
      if (frames != n0)
        return;
    end
    err_count++;
    stop_test();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(`SMR_IDX_COUNT, 32'h0);
    rchk(`SMR_IDX_RES_LOW, 32'h0);
    rchk(`SMR_IDX_RES_HIGH, 32'h0);
    rchk(`SMR_IDX_FEN, 32'h0);
    rchk(`SMR_IDX_FSEL, {26'h0, `SMR_FSEL_RST});
    rchk(`SMR_IDX_RSEL, 32'h1);
    rchk(`SMR_IDX_PER0, 32'h80);
    rchk(`SMR_IDX_PER2, 32'h0);
  endtask
  task automatic t_ro_write();
    bus(1, `SMR_IDX_RES_LOW, 32'hff, rd);
    bus(1, `SMR_IDX_RES_HIGH, 32'hff, rd);
    bus(1, `SMR_IDX_COUNT, 32'hff, rd);
    rchk(`SMR_IDX_RES_LOW, 32'h0);
    rchk(`SMR_IDX_RES_HIGH, 32'h0);
    rchk(`SMR_IDX_COUNT, 32'h0);
    rchk(12'h2ff, 32'h0);
  endtask
  task automatic t_peak_frame();
    sample_mag <= 20'h00011;
    sample_valid <= 1;
    bus(1, `SMR_IDX_CTRL, 32'h2, rd);
    bus(1, `SMR_IDX_PER0, 32'h40, rd);
    bus(1, `SMR_IDX_FEN, 32'h3, rd);
    wait_frame();
    cnt = last.count;
    // Short burst of a large value, then small ones: peak must hold the burst
    sample_mag <= 20'h92a5b;
    repeat (4) @(posedge mclk);
    sample_mag <= 20'h00011;
    wait_frame();
    check(last.peak_vld, 1'b1);
    check(last.peak, 20'h92a5b);
    check(last.count, 8'(cnt + 8'h1));
    cnt = last.count;
    rchk(`SMR_IDX_RES_LOW, 32'h5b);
    rchk(`SMR_IDX_RES_MID, 32'h2a);
    rchk(`SMR_IDX_RES_HIGH, 32'h9);
    rchk(`SMR_IDX_COUNT, {24'h0, cnt});
  endtask
  task automatic t_select();
    int n0;
    bus(1, `SMR_IDX_FSEL, 32'h0, rd);
    wait_frame();
    wait_frame();
    check(last.peak_vld, 1'b0);
    check(last.peak, 20'h0);
    rchk(`SMR_IDX_RES_LOW, 32'h11);
    bus(1, `SMR_IDX_RSEL, 32'h2, rd);
    wait_frame();
    wait_frame();
    rchk(`SMR_IDX_RSEL, 32'h2);
    rchk(`SMR_IDX_RES_LOW, 32'h0);
    bus(1, `SMR_IDX_RSEL, 32'h1, rd);
    bus(1, `SMR_IDX_FEN, 32'h1, rd);
    n0 = frames;
    repeat (140) @(posedge mclk);
    check(frames, n0);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    t_reset();
    t_ro_write();
    t_peak_frame();
    t_select();
    stop_test();
  end
endmodule

// ---- core/smr_defines.svh ----
// Constants for the signal monitor readback and framer
//
// Contract
// - Result bits 7:0 and 15:8 sit in two read-only registers; writes ignored.
// - Result bits 19:16 sit in the third register's low nibble; upper nibble zero.
// - Eight-bit read-only frame counter, plus one per period expiry, resets to zero.
// - A statistic enters the frame only when its selection bit is one.
// - Selection bit 1 inserts peak data; clear omits it; resets to one.
// - Result selection 001 routes the peak detector to the readback; reset 001.
// - Twenty-four-bit period in output clocks, any value, below two acts as two, reset 0x80.
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH

`define SMR_IDX_W 12
`define SMR_IDX_CTRL 12'h270
`define SMR_IDX_PER0 12'h271
`define SMR_IDX_PER1 12'h272
`define SMR_IDX_PER2 12'h273
`define SMR_IDX_RSEL 12'h274
`define SMR_IDX_RES_LOW 12'h275
`define SMR_IDX_RES_MID 12'h276
`define SMR_IDX_RES_HIGH 12'h277
`define SMR_IDX_COUNT 12'h278
`define SMR_IDX_FEN 12'h279
`define SMR_IDX_FSEL 12'h27a

`define SMR_PER_RST 24'h000080
`define SMR_RSEL_RST 3'h1
`define SMR_RSEL_PEAK 3'h1
`define SMR_FSEL_RST 6'h02
`define SMR_FSEL_PEAK 1
`define SMR_FEN_RST 2'h0
`define SMR_FEN_ON 2'h3
`define SMR_PDET_BIT 1

`endif

// ---- core/smr_framer.sv ----
// Signal monitor peak detector, readback registers and sideband frame source
`include "smr_defines.svh"

module smr_framer #(
  parameter int SAMPLE_W = 14
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [SAMPLE_W-1:0] sample_mag,
  input wire logic sample_valid,
  output smr_pkg::smr_frame_t frame_out
);

  if (SAMPLE_W < 1 || SAMPLE_W > 20)
  begin : g_chk
    $error("SAMPLE_W must be 1..20");
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [19:0] widen(input logic [SAMPLE_W-1:0] v);
    widen = 20'(v);
  endfunction

  function automatic logic [19:0] max20(input logic [19:0] a, input logic [19:0] b);
    max20 = (a > b) ? a : b;
  endfunction

  // ------------------------------------------------
  // State
  // ------------------------------------------------
  smr_pkg::smr_req_t req_reg, req_next;
  smr_pkg::smr_bus_t bus_reg, bus_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next;
  logic pdet_reg, pdet_next;
  logic [23:0] per_reg, per_next;
  logic [2:0] rsel_reg, rsel_next;
  logic [1:0] fen_reg, fen_next;
  logic [5:0] fsel_reg, fsel_next;
  logic [23:0] cnt_reg, cnt_next;
  logic [19:0] peak_reg, peak_next;
  logic [19:0] res_reg, res_next;
  logic [7:0] fcnt_reg, fcnt_next;
  smr_pkg::smr_frame_t frm_reg, frm_next;
  logic [23:0] per_m1;
  logic expire;
  logic [19:0] peak_final;
  logic do_wr;

  assign hrdata = rdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = 1'b0;
  assign frame_out = frm_reg;

  // ------------------------------------------------
  // Period and peak detector
  // ------------------------------------------------
  // Period expiry point
  always_comb
  begin
    per_m1 = (per_reg < 24'h000002) ? 24'h000001 : per_reg - 24'h000001;
    expire = (cnt_reg >= per_m1);
    peak_final = (sample_valid && pdet_reg) ? max20(peak_reg, widen(sample_mag)) : peak_reg;
  end

  always_comb
  begin
    cnt_next = expire ? 24'h000000 : cnt_reg + 24'h000001;
    peak_next = expire ? 20'h00000 : peak_final;
    res_next = res_reg;
    fcnt_next = fcnt_reg;
    frm_next = '0;
    if (expire)
    begin
      res_next = (rsel_reg == `SMR_RSEL_PEAK) ? peak_final : 20'h00000;
      fcnt_next = fcnt_reg + 8'h01;
      if (fen_reg == `SMR_FEN_ON)
      begin
        frm_next.valid = 1'b1;
        frm_next.count = fcnt_reg + 8'h01;
        if (fsel_reg[`SMR_FSEL_PEAK])
        begin
          frm_next.peak_vld = 1'b1;
          frm_next.peak = peak_final;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_reg <= 24'h000000;
      peak_reg <= 20'h00000;
      res_reg <= 20'h00000;
      fcnt_reg <= 8'h00;
      frm_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      peak_reg <= peak_next;
      res_reg <= res_next;
      fcnt_reg <= fcnt_next;
      frm_reg <= frm_next;
    end
  end

  // ------------------------------------------------
  // AHB-Lite slave and registers
  // ------------------------------------------------
  assign do_wr = req_reg.write && (bus_reg == smr_pkg::SMR_IDLE);

  always_comb
  begin
    req_next = req_reg;
    bus_next = bus_reg;
    rdata_next = rdata_reg;
    ready_next = 1'b1;
    pdet_next = pdet_reg;
    per_next = per_reg;
    rsel_next = rsel_reg;
    fen_next = fen_reg;
    fsel_next = fsel_reg;
    if (do_wr)
    begin
      unique case (req_reg.idx)
        `SMR_IDX_CTRL: pdet_next = hwdata[`SMR_PDET_BIT];
        `SMR_IDX_PER0: per_next[7:0] = hwdata[7:0];
        `SMR_IDX_PER1: per_next[15:8] = hwdata[7:0];
        `SMR_IDX_PER2: per_next[23:16] = hwdata[7:0];
        `SMR_IDX_RSEL: rsel_next = hwdata[2:0];
        `SMR_IDX_FEN: fen_next = hwdata[1:0];
        `SMR_IDX_FSEL: fsel_next = hwdata[5:0];
        default: ;
      endcase
    end
    unique case (bus_reg)
      smr_pkg::SMR_IDLE:
      begin
        req_next = '0;
        if (hsel && htrans[1] && hready)
        begin
          req_next.idx = haddr[`SMR_IDX_W+1:2];
          req_next.write = hwrite;
          req_next.read = !hwrite;
          if (!hwrite)
          begin
            bus_next = smr_pkg::SMR_RWAIT;
            ready_next = 1'b0;
          end
        end
      end
      smr_pkg::SMR_RWAIT:
      begin
        bus_next = smr_pkg::SMR_IDLE;
        req_next = '0;
        rdata_next = 32'h00000000;
        unique case (req_reg.idx)
          `SMR_IDX_CTRL: rdata_next[`SMR_PDET_BIT] = pdet_reg;
          `SMR_IDX_PER0: rdata_next[7:0] = per_reg[7:0];
          `SMR_IDX_PER1: rdata_next[7:0] = per_reg[15:8];
          `SMR_IDX_PER2: rdata_next[7:0] = per_reg[23:16];
          `SMR_IDX_RSEL: rdata_next[2:0] = rsel_reg;
          `SMR_IDX_RES_LOW: rdata_next[7:0] = res_reg[7:0];
          `SMR_IDX_RES_MID: rdata_next[7:0] = res_reg[15:8];
          `SMR_IDX_RES_HIGH: rdata_next[3:0] = res_reg[19:16];
          `SMR_IDX_COUNT: rdata_next[7:0] = fcnt_reg;
          `SMR_IDX_FEN: rdata_next[1:0] = fen_reg;
          `SMR_IDX_FSEL: rdata_next[5:0] = fsel_reg;
          default: ;
        endcase
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      req_reg <= '0;
      bus_reg <= smr_pkg::SMR_IDLE;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b1;
      pdet_reg <= 1'b0;
      per_reg <= `SMR_PER_RST;
      rsel_reg <= `SMR_RSEL_RST;
      fen_reg <= `SMR_FEN_RST;
      fsel_reg <= `SMR_FSEL_RST;
    end
    else
    begin
      req_reg <= req_next;
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      pdet_reg <= pdet_next;
      per_reg <= per_next;
      rsel_reg <= rsel_next;
      fen_reg <= fen_next;
      fsel_reg <= fsel_next;
    end
  end

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_result_ro: assert property (do_wr && !expire |=> res_reg == $past(res_reg))
    else $error("result changed by a write");

  a_high_resv: assert property (bus_reg == smr_pkg::SMR_RWAIT && req_reg.idx == `SMR_IDX_RES_HIGH
    |=> rdata_reg == {28'h0000000, $past(res_reg[19:16])})
    else $error("high result register read wrong");

  a_count_step: assert property (expire |=> fcnt_reg == $past(fcnt_reg) + 8'h01)
    else $error("frame counter did not step");

  a_frame_off: assert property (fen_reg != `SMR_FEN_ON |=> !frm_reg.valid)
    else $error("frame sent while disabled");

  a_peak_omit: assert property (frm_reg.valid && !$past(fsel_reg[`SMR_FSEL_PEAK])
    |-> !frm_reg.peak_vld && frm_reg.peak == 20'h00000)
    else $error("unselected peak in frame");

  a_peak_insert: assert property (expire && fen_reg == `SMR_FEN_ON && fsel_reg[`SMR_FSEL_PEAK]
    |=> frm_reg.peak_vld && frm_reg.count == fcnt_reg)
    else $error("peak missing from frame");

  a_route_sel: assert property (expire && rsel_reg != `SMR_RSEL_PEAK |=> res_reg == 20'h00000)
    else $error("result not cleared for other selection");

  // A period rewritten mid-count may end early once
  a_period_len: assert property (expire && per_reg >= 24'h000002 && $stable(per_reg)
    |-> cnt_reg == per_reg - 24'h000001)
    else $error("period expiry at wrong count");

  a_period_wrap: assert property (expire |=> cnt_reg == 24'h000000)
    else $error("period counter did not restart");

  a_sync_update: assert property ($changed(res_reg) |-> $changed(fcnt_reg))
    else $error("result updated apart from counter");

  a_read_wait: assert property (bus_reg == smr_pkg::SMR_RWAIT |-> !ready_reg ##1 ready_reg)
    else $error("read wait state wrong");

  c_frame_peak: cover property (frm_reg.valid && frm_reg.peak_vld);
  c_frame_nopeak: cover property (frm_reg.valid && !frm_reg.peak_vld);
  c_read_result: cover property (bus_reg == smr_pkg::SMR_RWAIT && req_reg.idx == `SMR_IDX_RES_LOW);
  c_write_period: cover property (do_wr && req_reg.idx == `SMR_IDX_PER0);
  c_route_other: cover property (expire && rsel_reg != `SMR_RSEL_PEAK);

endmodule

// ---- core/smr_pkg.sv ----
// Types shared by the signal monitor readback and framer
package smr_pkg;

  typedef struct packed {
    logic [11:0] idx;
    logic write;
    logic read;
  } smr_req_t;

  typedef struct packed {
    logic valid;
    logic peak_vld;
    logic [19:0] peak;
    logic [7:0] count;
  } smr_frame_t;

  typedef enum logic {SMR_IDLE, SMR_RWAIT} smr_bus_t;

endpackage
